// ---- common/shbp_pkg.sv ----
// shared constants and carrier types for the switch host bridge port
// assumes one 125 MHz clock; the bridge on the far side keeps its own rules
package shbp_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_NS        = 8;
  localparam int STAT_CLK_NS   = 25;
  // least half period, rounded up to whole cycles
  localparam int STAT_HALF_CYC = (STAT_CLK_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);

  // ------------------------------------------------------------------
  // mailbox layout (word addresses in sdram)
  // ------------------------------------------------------------------
  localparam logic [21:0] MBOX_ADDR   = 22'h0;
  localparam logic [21:0] MB_CMD_OFS  = 22'h0;
  localparam logic [21:0] MB_DATA_OFS = 22'h1;
  localparam logic [21:0] MB_PKT_OFS  = 22'h2;
  localparam int          CMD_MSB     = 31;
  localparam int          CMD_LSB     = 30;
  localparam logic [1:0]  CMD_REG_RD  = 2'h1;
  localparam logic [1:0]  CMD_REG_WR  = 2'h2;
  localparam logic [1:0]  CMD_SEND    = 2'h3;

  // ------------------------------------------------------------------
  // ports, header and statistics
  // ------------------------------------------------------------------
  localparam logic [4:0]  HOST_PORT   = 5'h1a;
  localparam int          HOST_FLAG   = 31;
  localparam int          HDR_WORDS   = 3;
  localparam int          HDR_DEPTH   = 4;
  localparam logic [3:0]  RX_VEC_NIB  = 4'h8;
  localparam logic [3:0]  TX_VEC_NIB  = 4'hd;
  localparam logic [3:0]  STAT_IDLE   = 4'hf;

  typedef struct packed {
    logic        we;
    logic [21:0] addr;
    logic [31:0] wdata;
  } shbp_mem_cmd_type;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } shbp_reg_cmd_type;

  typedef struct packed {
    logic [4:0]  src_port;
    logic [21:0] buf_addr;
    logic [15:0] len;
  } shbp_tx_cmd_type;

  typedef struct packed {
    logic [21:0] buf_addr;
    logic [26:0] dst_map;
    logic [31:0] hdr0;
    logic [31:0] hdr1;
  } shbp_rx_hdr_type;

  typedef struct packed {
    logic        is_tx;
    logic [48:0] bits;
  } shbp_stat_vec_type;

endpackage

// ---- rtl/shbp_hdr_mem.sv ----
// small header queue memory, one entry per received packet
// assumes one write and one read port on the same clock; read data registered
`timescale 1ns/1ns
module shbp_hdr_mem (
  input  wire logic        ref_clk_in,
  input  wire logic        wr_en_in,
  input  wire logic [1:0]  wr_addr_in,
  input  wire logic [95:0] wr_data_in,
  input  wire logic [1:0]  rd_addr_in,
  output logic      [95:0] rd_data_out
);
  logic [95:0] mem_ff [0:3];

  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_ff[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_ff[rd_addr_in];
  end
endmodule

// ---- rtl/shbp_port.sv ----
// host bridge port of the switch: mailbox engine, bus arbitration,
// header strobe output and statistics nibble output
// assumes pins from the bridge are asynchronous; all else on ref_clk_in
`timescale 1ns/1ns
module shbp_port (
  input  wire logic                       ref_clk_in,
  input  wire logic                       reset_in,
  input  wire logic                       command_ready_line_in,
  input  wire logic                       bus_request_line_in,
  output logic                            task_complete_line_out,
  output logic                            bus_grant_line_out,
  output logic                            header_strobe_out,
  output logic      [31:0]                ext_data_out,
  output logic                            ext_data_oe_n_out,
  output logic                            mem_req_out,
  output shbp_pkg::shbp_mem_cmd_type      mem_cmd_out,
  input  wire logic                       mem_ack_in,
  input  wire logic [31:0]                mem_rdata_in,
  output logic                            reg_req_out,
  output shbp_pkg::shbp_reg_cmd_type      reg_cmd_out,
  input  wire logic                       reg_ack_in,
  input  wire logic [31:0]                reg_rdata_in,
  output logic                            tx_req_out,
  output shbp_pkg::shbp_tx_cmd_type       tx_cmd_out,
  input  wire logic                       tx_ack_in,
  input  wire logic                       rx_hdr_valid_in,
  input  wire shbp_pkg::shbp_rx_hdr_type  rx_hdr_in,
  output logic                            rx_hdr_ready_out,
  input  wire logic                       stat_valid_in,
  input  wire shbp_pkg::shbp_stat_vec_type stat_vec_in,
  output logic                            stat_ready_out,
  output logic                            stat_clk_out,
  output logic      [3:0]                 stat_data_out
);
  import shbp_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic cmd_meta_ff, cmd_sync_ff, cmd_prev_ff;
  logic req_meta_ff, req_sync_ff;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cmd_meta_ff <= 1'b0;
      cmd_sync_ff <= 1'b0;
      cmd_prev_ff <= 1'b0;
      req_meta_ff <= 1'b0;
      req_sync_ff <= 1'b0;
    end else begin
      cmd_meta_ff <= command_ready_line_in;
      cmd_sync_ff <= cmd_meta_ff;
      cmd_prev_ff <= cmd_sync_ff;
      req_meta_ff <= bus_request_line_in;
      req_sync_ff <= req_meta_ff;
    end
  end

  // command-ready is taken on its rising edge, so a held level runs once
  logic cmd_rise;
  assign cmd_rise = cmd_sync_ff & ~cmd_prev_ff;

  // ------------------------------------------------------------------
  // header queue
  // ------------------------------------------------------------------
  logic [1:0]  hq_wr_ff, nxt_hq_wr;
  logic [1:0]  hq_rd_ff, nxt_hq_rd;
  logic [2:0]  hq_cnt_ff, nxt_hq_cnt;
  logic        hq_push;
  logic        hq_pop;
  logic [95:0] hq_wdata;
  logic [95:0] hq_rdata;

  // host-bound flag sits in the address word; header itself is unchanged
  assign hq_wdata = {rx_hdr_in.dst_map[HOST_PORT], 9'h000, rx_hdr_in.buf_addr,
                     rx_hdr_in.hdr0, rx_hdr_in.hdr1};
  assign hq_push  = rx_hdr_valid_in & rx_hdr_ready_out;

  shbp_hdr_mem u_hdr_mem (
    .ref_clk_in  (ref_clk_in),
    .wr_en_in    (hq_push),
    .wr_addr_in  (hq_wr_ff),
    .wr_data_in  (hq_wdata),
    .rd_addr_in  (hq_rd_ff),
    .rd_data_out (hq_rdata)
  );

  // ------------------------------------------------------------------
  // mailbox engine, bus arbitration and header output
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_MB_CMD = 4'h1,
    ST_MB_DAT = 4'h2,
    ST_REG    = 4'h3,
    ST_MB_WR  = 4'h4,
    ST_SEND   = 4'h5,
    ST_DONE   = 4'h6,
    ST_GRANT  = 4'h7,
    ST_HDR    = 4'h8
  } shbp_state_type;

  shbp_state_type    st_ff, nxt_st;
  shbp_mem_cmd_type  mem_cmd_ff, nxt_mem_cmd;
  shbp_reg_cmd_type  reg_cmd_ff, nxt_reg_cmd;
  shbp_tx_cmd_type   tx_cmd_ff, nxt_tx_cmd;
  logic              mem_req_ff, nxt_mem_req;
  logic              reg_req_ff, nxt_reg_req;
  logic              tx_req_ff, nxt_tx_req;
  logic              done_ff, nxt_done;
  logic              grant_ff, nxt_grant;
  logic              strobe_ff, nxt_strobe;
  logic              oe_n_ff, nxt_oe_n;
  logic [31:0]       ext_ff, nxt_ext;
  logic [1:0]        cmd_ff, nxt_cmd;
  logic [1:0]        hidx_ff, nxt_hidx;
  logic              pend_ff, nxt_pend;

  always_comb begin
    nxt_st      = st_ff;
    nxt_mem_cmd = mem_cmd_ff;
    nxt_reg_cmd = reg_cmd_ff;
    nxt_tx_cmd  = tx_cmd_ff;
    nxt_mem_req = mem_req_ff;
    nxt_reg_req = reg_req_ff;
    nxt_tx_req  = tx_req_ff;
    nxt_done    = 1'b0;
    nxt_grant   = grant_ff;
    nxt_strobe  = 1'b0;
    nxt_oe_n    = 1'b1;
    nxt_ext     = 32'h0;
    nxt_cmd     = cmd_ff;
    nxt_hidx    = hidx_ff;
    nxt_pend    = pend_ff | cmd_rise;
    nxt_hq_rd   = hq_rd_ff;
    hq_pop      = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        // headers first: they carry live traffic; then granting, then mailbox
        if (hq_cnt_ff != 3'h0) begin
          nxt_hidx = 2'h0;
          nxt_st   = ST_HDR;
        end else if (req_sync_ff) begin
          nxt_grant = 1'b1;
          nxt_st    = ST_GRANT;
        end else if (pend_ff) begin
          nxt_pend    = cmd_rise;
          nxt_mem_req = 1'b1;
          nxt_mem_cmd = '{we: 1'b0, addr: MBOX_ADDR + MB_CMD_OFS, wdata: 32'h0};
          nxt_st      = ST_MB_CMD;
        end
      end
      ST_MB_CMD: begin
        if (mem_ack_in) begin
          nxt_cmd     = mem_rdata_in[CMD_MSB:CMD_LSB];
          nxt_reg_cmd = '{we: 1'b0, addr: mem_rdata_in[15:0], wdata: 32'h0};
          nxt_mem_cmd = '{we: 1'b0, addr: MBOX_ADDR + MB_DATA_OFS, wdata: 32'h0};
          case (mem_rdata_in[CMD_MSB:CMD_LSB])
            CMD_REG_RD: begin
              nxt_mem_req = 1'b0;
              nxt_reg_req = 1'b1;
              nxt_st      = ST_REG;
            end
            CMD_REG_WR, CMD_SEND: begin
              nxt_st = ST_MB_DAT;
            end
            default: begin
              // unknown command: nothing to do, still report completion
              nxt_mem_req = 1'b0;
              nxt_done    = 1'b1;
              nxt_st      = ST_DONE;
            end
          endcase
        end
      end
      ST_MB_DAT: begin
        if (mem_ack_in) begin
          nxt_mem_req = 1'b0;
          if (cmd_ff == CMD_SEND) begin
            // packet already sits in the mailbox; word holds its length
            nxt_tx_req = 1'b1;
            nxt_tx_cmd = '{src_port: HOST_PORT, buf_addr: MBOX_ADDR + MB_PKT_OFS,
                           len: mem_rdata_in[15:0]};
            nxt_st     = ST_SEND;
          end else begin
            nxt_reg_req       = 1'b1;
            nxt_reg_cmd.we    = 1'b1;
            nxt_reg_cmd.wdata = mem_rdata_in;
            nxt_st            = ST_REG;
          end
        end
      end
      ST_REG: begin
        if (reg_ack_in) begin
          nxt_reg_req = 1'b0;
          if (reg_cmd_ff.we) begin
            nxt_done = 1'b1;
            nxt_st   = ST_DONE;
          end else begin
            nxt_mem_req = 1'b1;
            nxt_mem_cmd = '{we: 1'b1, addr: MBOX_ADDR + MB_DATA_OFS,
                            wdata: reg_rdata_in};
            nxt_st      = ST_MB_WR;
          end
        end
      end
      ST_MB_WR: begin
        if (mem_ack_in) begin
          nxt_mem_req = 1'b0;
          nxt_done    = 1'b1;
          nxt_st      = ST_DONE;
        end
      end
      ST_SEND: begin
        if (tx_ack_in) begin
          nxt_tx_req = 1'b0;
          nxt_done   = 1'b1;
          nxt_st     = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_st = ST_IDLE;
      end
      ST_GRANT: begin
        // the switch's own mailbox traffic waits while the bridge owns the bus
        if (!req_sync_ff) begin
          nxt_grant = 1'b0;
          nxt_st    = ST_IDLE;
        end
      end
      ST_HDR: begin
        // cycle 0 waits for registered read data, then three words follow
        nxt_hidx = hidx_ff + 2'h1;
        if (hidx_ff != 2'h0) begin
          nxt_oe_n = 1'b0;
          case (hidx_ff)
            2'h1:    nxt_ext = hq_rdata[95:64];
            2'h2:    nxt_ext = hq_rdata[63:32];
            default: nxt_ext = hq_rdata[31:0];
          endcase
          nxt_strobe = (hidx_ff == 2'h1);
        end
        if (hidx_ff == 2'(HDR_WORDS)) begin
          hq_pop    = 1'b1;
          nxt_hq_rd = hq_rd_ff + 2'h1;
          nxt_st    = ST_IDLE;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    nxt_hq_wr  = hq_push ? hq_wr_ff + 2'h1 : hq_wr_ff;
    nxt_hq_cnt = hq_cnt_ff + {2'h0, hq_push} - {2'h0, hq_pop};
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_ff      <= ST_IDLE;
      mem_cmd_ff <= '0;
      reg_cmd_ff <= '0;
      tx_cmd_ff  <= '0;
      mem_req_ff <= 1'b0;
      reg_req_ff <= 1'b0;
      tx_req_ff  <= 1'b0;
      done_ff    <= 1'b0;
      grant_ff   <= 1'b0;
      strobe_ff  <= 1'b0;
      oe_n_ff    <= 1'b1;
      ext_ff     <= 32'h0;
      cmd_ff     <= 2'h0;
      hidx_ff    <= 2'h0;
      pend_ff    <= 1'b0;
      hq_wr_ff   <= 2'h0;
      hq_rd_ff   <= 2'h0;
      hq_cnt_ff  <= 3'h0;
    end else begin
      st_ff      <= nxt_st;
      mem_cmd_ff <= nxt_mem_cmd;
      reg_cmd_ff <= nxt_reg_cmd;
      tx_cmd_ff  <= nxt_tx_cmd;
      mem_req_ff <= nxt_mem_req;
      reg_req_ff <= nxt_reg_req;
      tx_req_ff  <= nxt_tx_req;
      done_ff    <= nxt_done;
      grant_ff   <= nxt_grant;
      strobe_ff  <= nxt_strobe;
      oe_n_ff    <= nxt_oe_n;
      ext_ff     <= nxt_ext;
      cmd_ff     <= nxt_cmd;
      hidx_ff    <= nxt_hidx;
      pend_ff    <= nxt_pend;
      hq_wr_ff   <= nxt_hq_wr;
      hq_rd_ff   <= nxt_hq_rd;
      hq_cnt_ff  <= nxt_hq_cnt;
    end
  end

  assign task_complete_line_out = done_ff;
  assign bus_grant_line_out     = grant_ff;
  assign header_strobe_out      = strobe_ff;
  assign ext_data_out           = ext_ff;
  assign ext_data_oe_n_out      = oe_n_ff;
  assign mem_req_out            = mem_req_ff;
  assign mem_cmd_out            = mem_cmd_ff;
  assign reg_req_out            = reg_req_ff;
  assign reg_cmd_out            = reg_cmd_ff;
  assign tx_req_out             = tx_req_ff;
  assign tx_cmd_out             = tx_cmd_ff;

  // ------------------------------------------------------------------
  // statistics nibble output
  // ------------------------------------------------------------------
  logic [51:0] sh_ff, nxt_sh;
  logic [3:0]  nib_ff, nxt_nib;
  logic [1:0]  div_ff, nxt_div;
  logic        sclk_ff, nxt_sclk;
  logic [3:0]  sdat_ff, nxt_sdat;
  logic        sbusy_ff, nxt_sbusy;
  logic        hq_rdy_ff, nxt_hq_rdy;
  logic        tick;

  assign tick = (div_ff == 2'(STAT_HALF_CYC - 1));

  always_comb begin
    nxt_sh     = sh_ff;
    nxt_nib    = nib_ff;
    nxt_sdat   = sdat_ff;
    nxt_sbusy  = sbusy_ff;
    nxt_sclk   = sclk_ff;
    nxt_div    = tick ? 2'h0 : div_ff + 2'h1;
    // ready is registered, so it counts the word that may land this cycle
    nxt_hq_rdy = (nxt_hq_cnt < 3'(HDR_DEPTH));
    if (tick) begin
      nxt_sclk = ~sclk_ff;
      // data changes only as the clock falls, stable for the rising edge
      if (sclk_ff) begin
        if (sbusy_ff && nib_ff != 4'h0) begin
          nxt_sdat = sh_ff[3:0];
          nxt_sh   = {4'h0, sh_ff[51:4]};
          nxt_nib  = nib_ff - 4'h1;
        end else if (sbusy_ff) begin
          nxt_sbusy = 1'b0;
          nxt_sdat  = STAT_IDLE;
        end else if (stat_valid_in) begin
          nxt_sbusy = 1'b1;
          nxt_sdat  = stat_vec_in.bits[3:0];
          nxt_sh    = {7'h00, stat_vec_in.bits[48:4]};
          nxt_nib   = (stat_vec_in.is_tx ? TX_VEC_NIB : RX_VEC_NIB) - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sh_ff     <= 52'h0;
      nib_ff    <= 4'h0;
      div_ff    <= 2'h0;
      sclk_ff   <= 1'b0;
      sdat_ff   <= STAT_IDLE;
      sbusy_ff  <= 1'b0;
      hq_rdy_ff <= 1'b0;
    end else begin
      sh_ff     <= nxt_sh;
      nib_ff    <= nxt_nib;
      div_ff    <= nxt_div;
      sclk_ff   <= nxt_sclk;
      sdat_ff   <= nxt_sdat;
      sbusy_ff  <= nxt_sbusy;
      hq_rdy_ff <= nxt_hq_rdy;
    end
  end

  // vector taken on the falling-edge tick when the shifter is free
  logic stat_rdy_ff;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      stat_rdy_ff <= 1'b0;
    end else begin
      stat_rdy_ff <= tick & sclk_ff & ~sbusy_ff;
    end
  end

  assign stat_ready_out   = stat_rdy_ff;
  assign stat_clk_out     = sclk_ff;
  assign stat_data_out    = sdat_ff;
  assign rx_hdr_ready_out = hq_rdy_ff;
endmodule

// ---- verif/shbp_bridge_model.sv ----
// bus bridge model: raises command ready and bus request, waits for the answers
// assumes the testbench calls its tasks; pins change on the falling edge only
`timescale 1ns/1ns
module shbp_bridge_model (
  input  wire logic ref_clk_in,
  input  wire logic task_complete_line_in,
  input  wire logic bus_grant_line_in,
  output logic      command_ready_line_out,
  output logic      bus_request_line_out
);
  initial begin
    command_ready_line_out = 1'b0;
    bus_request_line_out = 1'b0;
  end
  task automatic run_command(output logic ok);
    ok = 1'b0;
    @(negedge ref_clk_in);
    command_ready_line_out = 1'b1;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(negedge ref_clk_in);
      ok = (task_complete_line_in === 1'b1);
    end
    @(negedge ref_clk_in);
    command_ready_line_out = 1'b0;
    // low long enough for the pin synchroniser to see the next rise
    repeat (4) @(negedge ref_clk_in);
  endtask
  task automatic request_bus(input int hold, output logic granted);
    granted = 1'b0;
    @(negedge ref_clk_in);
    bus_request_line_out = 1'b1;
    // no sdram access before the grant is seen
    for (int i = 0; i < 300 && !granted; i++) begin
      @(negedge ref_clk_in);
      granted = (bus_grant_line_in === 1'b1);
    end
    // burst beats: address and control are the bridge's only while granted
    for (int i = 0; i < hold; i++) begin
      @(negedge ref_clk_in);
      granted &= (bus_grant_line_in === 1'b1);
    end
    bus_request_line_out = 1'b0;
  endtask
endmodule

// ---- verif/shbp_port_chk.sv ----
// concurrent checks on the host bridge port pins and internal request ports
// assumes it is bound onto shbp_port; one clock, synchronous active high reset
`timescale 1ns/1ns
module shbp_port_chk (
  input wire logic                       ref_clk_in,
  input wire logic                       reset_in,
  input wire logic                       bus_request_line_in,
  input wire logic                       task_complete_line_out,
  input wire logic                       bus_grant_line_out,
  input wire logic                       header_strobe_out,
  input wire logic [31:0]                ext_data_out,
  input wire logic                       ext_data_oe_n_out,
  input wire logic                       mem_req_out,
  input wire shbp_pkg::shbp_mem_cmd_type mem_cmd_out,
  input wire logic                       reg_req_out,
  input wire logic                       tx_req_out,
  input wire shbp_pkg::shbp_tx_cmd_type  tx_cmd_out
);
  import shbp_pkg::*;
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_done_one_cycle: assert property (task_complete_line_out |=> !task_complete_line_out)
    else $error("task complete longer than one cycle");
  a_grant_after_req: assert property ($rose(bus_grant_line_out) |->
      $past(bus_request_line_in, 2) && $past(bus_request_line_in, 3))
    else $error("grant without synced request");
  a_grant_release: assert property ($fell(bus_request_line_in) |-> ##[1:4] !bus_grant_line_out)
    else $error("grant held after request dropped");
  a_no_bus_clash: assert property (bus_grant_line_out |-> !mem_req_out)
    else $error("mailbox access while bus granted");
  // a read result going back to word one follows a register access, not a new command
  a_mbox_at_zero: assert property ($rose(mem_req_out) && !$past(reg_req_out) |->
      mem_cmd_out.addr == (MBOX_ADDR + MB_CMD_OFS) && !mem_cmd_out.we)
    else $error("mailbox command not read from word zero");
  a_strobe_pulse: assert property (header_strobe_out |=> !header_strobe_out)
    else $error("header strobe longer than one cycle");
  a_three_words: assert property (header_strobe_out |-> !ext_data_oe_n_out [*3])
    else $error("header words not driven for three cycles");
  a_strobe_first: assert property ($fell(ext_data_oe_n_out) |-> header_strobe_out)
    else $error("bus driven without header strobe");
  a_idle_bus_zero: assert property (ext_data_oe_n_out |-> ext_data_out == 32'h0)
    else $error("external data not zero while released");
  a_tx_host_port: assert property (tx_req_out |->
      tx_cmd_out.src_port == HOST_PORT && tx_cmd_out.buf_addr == MB_PKT_OFS)
    else $error("packet send not from host port and mailbox");
endmodule

bind shbp_port shbp_port_chk u_chk (.ref_clk_in, .reset_in, .bus_request_line_in,
  .task_complete_line_out, .bus_grant_line_out, .header_strobe_out, .ext_data_out,
  .ext_data_oe_n_out, .mem_req_out, .mem_cmd_out, .reg_req_out, .tx_req_out, .tx_cmd_out);

// ---- verif/test_switch_host_bridge_port.sv ----
// self-checking bench for shbp_port with a bridge model and sdram responders
// assumes the checker is bound from its own file; inputs change on falling edges
`timescale 1ns/1ns
module test_switch_host_bridge_port;
  import shbp_pkg::*;
  logic              ref_clk_in = 1'b0;
  logic              reset_in = 1'b1;
  logic              cmd_rdy, bus_req, done, grant, strobe, oe_n, mem_req, reg_req, tx_req;
  logic              mem_ack_in = 1'b0, reg_ack_in = 1'b0, tx_ack_in = 1'b0;
  logic              rx_hdr_valid_in = 1'b0, stat_valid_in = 1'b0, rx_rdy, stat_rdy, stat_clk;
  shbp_stat_vec_type stat_vec_in = '0;
  logic [31:0]       ext_data, mem_rdata_in = 32'h0, reg_rdata_in = 32'h0;
  logic [31:0]       mbox [4];
  logic [3:0]        stat_data;
  shbp_mem_cmd_type  mem_cmd;
  shbp_reg_cmd_type  reg_cmd, seen_reg;
  shbp_tx_cmd_type   tx_cmd, seen_tx;
  shbp_rx_hdr_type   rx_hdr_in = '0;
  int                mismatches = 0;
  int                checks_done = 0;

  always #4 ref_clk_in = ~ref_clk_in;
  shbp_port DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .command_ready_line_in(cmd_rdy), .bus_request_line_in(bus_req),
    .task_complete_line_out(done), .bus_grant_line_out(grant), .header_strobe_out(strobe),
    .ext_data_out(ext_data), .ext_data_oe_n_out(oe_n), .mem_req_out(mem_req),
    .mem_cmd_out(mem_cmd), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
    .reg_req_out(reg_req), .reg_cmd_out(reg_cmd), .reg_ack_in(reg_ack_in),
    .reg_rdata_in(reg_rdata_in), .tx_req_out(tx_req), .tx_cmd_out(tx_cmd),
    .tx_ack_in(tx_ack_in), .rx_hdr_valid_in(rx_hdr_valid_in), .rx_hdr_in(rx_hdr_in),
    .rx_hdr_ready_out(rx_rdy), .stat_valid_in(stat_valid_in), .stat_vec_in(stat_vec_in),
    .stat_ready_out(stat_rdy), .stat_clk_out(stat_clk), .stat_data_out(stat_data));
  shbp_bridge_model bridge (.ref_clk_in(ref_clk_in), .task_complete_line_in(done),
    .bus_grant_line_in(grant), .command_ready_line_out(cmd_rdy),
    .bus_request_line_out(bus_req));

  // ------------------------------------------------------------------
  // sdram and register responders, one ack per request
  // ------------------------------------------------------------------
  always @(negedge ref_clk_in) begin
    mem_ack_in <= mem_req && !mem_ack_in;
    mem_rdata_in <= mbox[mem_cmd.addr[1:0]];
    reg_ack_in <= reg_req && !reg_ack_in;
    tx_ack_in <= tx_req && !tx_ack_in;
  end
  always @(posedge ref_clk_in) begin
    if (mem_req && mem_ack_in && mem_cmd.we)
      mbox[mem_cmd.addr[1:0]] <= mem_cmd.wdata;
    if (reg_req && reg_ack_in)
      seen_reg <= reg_cmd;
    if (tx_req && tx_ack_in)
      seen_tx <= tx_cmd;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    repeat (2) @(negedge ref_clk_in);
    check("reset pins", {done, grant, strobe, oe_n, ext_data}, {3'h0, 1'b1, 32'h0});
    check("stat idle", stat_data, STAT_IDLE);
    reset_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    $display("test reset done");
  endtask
  task automatic t_mailbox(input logic [1:0] cmd, input logic [15:0] ra, input logic [31:0] d);
    logic ok;
    mbox[0] = {cmd, 14'h0, ra};
    mbox[1] = d;
    reg_rdata_in = ~d;
    seen_reg = '0;
    seen_tx = '0;
    bridge.run_command(ok);
    check("task done", ok, 1'b1);
    case (cmd)
      CMD_REG_WR: check("reg write", seen_reg, {1'b1, ra, d});
      CMD_REG_RD: begin
        check("reg read", {seen_reg.we, seen_reg.addr}, {1'b0, ra});
        check("read result", mbox[1], 32'(~d));
      end
      CMD_SEND: check("send", seen_tx, {HOST_PORT, MB_PKT_OFS, d[15:0]});
      default: check("no access", {seen_reg, seen_tx}, '0);
    endcase
    $display("test mailbox %0d done", cmd);
  endtask
  task automatic t_bus();
    logic ok;
    logic g;
    fork
      bridge.run_command(ok);
      bridge.request_bus(6, g);
    join
    check("grant", {ok, g}, 2'h3);
    repeat (5) @(negedge ref_clk_in);
    check("grant released", grant, 1'b0);
    $display("test bus done");
  endtask
  task automatic t_header(input logic host);
    shbp_rx_hdr_type h;
    logic [31:0]     w [3];
    int              n;
    h = {22'h2a5c3, host, 26'h0000055, 32'hc0de0001, 32'h1234abcd};
    @(negedge ref_clk_in);
    rx_hdr_in = h;
    rx_hdr_valid_in = 1'b1;
    // ready is registered, so its level here is what the next edge sees
    for (n = 0; n < 20 && rx_rdy !== 1'b1; n++) begin
      @(negedge ref_clk_in);
    end
    @(negedge ref_clk_in);
    rx_hdr_valid_in = 1'b0;
    rx_hdr_in = ~h;
    for (n = 0; n < 20; n++) begin
      @(negedge ref_clk_in);
      if (strobe === 1'b1) break;
    end
    check("strobe", strobe, 1'b1);
    for (n = 0; n < 3; n++) begin
      w[n] = ext_data;
      @(negedge ref_clk_in);
    end
    check("word0", w[0], {host, 9'h0, h.buf_addr});
    check("host flag", w[0][31], host);
    check("words", {w[1], w[2]}, {h.hdr0, h.hdr1});
    $display("test header %0d done", host);
  endtask
  task automatic t_stat(input logic tx, input logic [48:0] v);
    logic [51:0] got;
    logic [3:0]  gap;
    logic        prev;
    int          k;
    int          n;
    int          nibs;
    got = '0;
    gap = 4'h0;
    k = 0;
    nibs = int'(tx ? TX_VEC_NIB : RX_VEC_NIB);
    @(negedge ref_clk_in);
    stat_vec_in = '{is_tx: tx, bits: v};
    stat_valid_in = 1'b1;
    // ready follows the edge that took the vector, so look only after one edge
    for (n = 0; n < 20; n++) begin
      @(negedge ref_clk_in);
      if (stat_rdy === 1'b1) break;
    end
    check("stat taken", n < 20, 1'b1);
    @(negedge ref_clk_in);
    stat_valid_in = 1'b0;
    prev = stat_clk;
    for (n = 0; n < 200 && k <= nibs; n++) begin
      @(negedge ref_clk_in);
      if (stat_clk === 1'b1 && prev === 1'b0) begin
        if (k < nibs) begin
          got[4*k +: 4] = stat_data;
        end else begin
          gap = stat_data;
        end
        k++;
      end
      prev = stat_clk;
    end
    check("stat vector", got, tx ? {3'h0, v} : {20'h0, v[31:0]});
    check("stat gap", gap, STAT_IDLE);
    $display("test stat %0d done", tx);
  endtask

  initial begin
    t_reset();
    t_mailbox(CMD_REG_WR, 16'h0123, 32'h89abcdef);
    t_mailbox(CMD_REG_RD, 16'hfffe, 32'h13572468);
    t_mailbox(CMD_SEND, 16'h0000, 32'h000005ee);
    t_mailbox(2'h0, 16'h0040, 32'h0000ffff);
    t_bus();
    t_header(1'b1);
    t_header(1'b0);
    t_stat(1'b0, 49'h000087654321);
    t_stat(1'b1, 49'h1a5a5c3c3e1e1);
    tally_and_finish();
  end
  initial begin
    #60000;
    mismatches++;
    tally_and_finish();
  end
endmodule
